/* File: src/xcp_port.sv */
// serial load register and active route registers of the crosspoint
`timescale 1ns/1ps
`default_nettype none
`include "xcp_params.svh"
module xcp_port (
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire logic                      sclk,
  input  wire logic                      sdin,
  input  wire logic                      cs_b,
  input  wire logic                      mode_sel,
  input  wire logic                      cfg,
  output logic                           sdout,
  output xcp_pkg::xcp_route_s [7:0]      route,
  output logic                           pending
);
  import xcp_pkg::*;

  // ==========================================================
  // pin synchronisers
  xcp_pins_s pins_in;
  xcp_pins_s meta_q;
  xcp_pins_s sync_q;
  xcp_pins_s prev_q;

  assign pins_in = '{sclk: sclk, sdin: sdin, cs_b: cs_b,
                     mode_sel: mode_sel, cfg: cfg};

  // two stages, then one history stage for edges
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '{sclk: 1'b0, sdin: 1'b0, cs_b: 1'b1,
                  mode_sel: 1'b0, cfg: 1'b0};
      sync_q <= '{sclk: 1'b0, sdin: 1'b0, cs_b: 1'b1,
                  mode_sel: 1'b0, cfg: 1'b0};
      prev_q <= '{sclk: 1'b0, sdin: 1'b0, cs_b: 1'b1,
                  mode_sel: 1'b0, cfg: 1'b0};
    end else begin
      meta_q <= pins_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // ==========================================================
  // edge decode
  logic sclk_rise;
  logic sclk_fall;
  logic cfg_rise;
  logic selected;

  assign selected  = ~sync_q.cs_b;
  assign sclk_rise = sync_q.sclk & ~prev_q.sclk;
  assign sclk_fall = ~sync_q.sclk & prev_q.sclk;
  assign cfg_rise  = sync_q.cfg & ~prev_q.cfg;

  // ==========================================================
  // arming and shifting
  logic                        armed_q;
  logic                        armed_d;
  logic                        shift_en;
  logic [`XCP_FRAME_BITS-1:0]  load_q;
  logic [`XCP_FRAME_BITS-1:0]  load_d;
  logic                        sdout_q;
  logic                        sdout_d;

  // first rising edge with select low arms; select high disarms
  assign armed_d  = selected & (armed_q | sclk_rise);
  // bits taken on falling edges only once armed
  assign shift_en = selected & armed_q & sclk_fall;
  // new bit enters at the top, oldest leaves at bit 0
  assign load_d   = shift_en ? {sync_q.sdin,
                                load_q[`XCP_FRAME_BITS-1:1]}
                             : load_q;
  assign sdout_d  = shift_en ? load_q[0] : sdout_q;

  // load register and serial output
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
      load_q  <= '0;
      sdout_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
      load_q  <= load_d;
      sdout_q <= sdout_d;
    end
  end

  // ==========================================================
  // pending new data flag
  logic pend_q;
  logic pend_d;
  logic apply;

  // a configure only acts when something new was shifted
  assign apply  = cfg_rise & pend_q;
  // a shift in the same cycle as the clear keeps the flag set
  assign pend_d = shift_en | (pend_q & ~apply);

  // pending flag register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // ==========================================================
  // addressed word decode
  logic [`XCP_WORD_BITS-1:0]  word;
  logic [`XCP_ADR_OUT_W-1:0]  word_tgt;
  xcp_route_s                 word_route;

  // the last eight bits received sit at the top of the load register
  assign word     = load_q[`XCP_WORD_LSB +: `XCP_WORD_BITS];
  assign word_tgt = word[`XCP_ADR_OUT_LSB +: `XCP_ADR_OUT_W];
  assign word_route = '{off: word[`XCP_ADR_OFF_POS],
                        sel: word[`XCP_ADR_IN_LSB +: `XCP_SEL_BITS]};

  // ==========================================================
  // active route registers, one per output
  xcp_route_s [`XCP_NUM_OUT-1:0] route_q;
  xcp_route_s [`XCP_NUM_OUT-1:0] route_d;
  xcp_route_s                    route_rst;

  // every output off and on input zero after reset
  assign route_rst = '{off: `XCP_RST_OFF, sel: `XCP_RST_SEL};

  genvar gi;
  generate
    for (gi = 0; gi < `XCP_NUM_OUT; gi = gi + 1) begin : g_out
      xcp_route_s frame_route;
      logic       hit;
      // five bits per output, select lsb first then off bit
      assign frame_route = '{
        off: load_q[gi*`XCP_SLOT_BITS + `XCP_SER_OFF_POS],
        sel: load_q[gi*`XCP_SLOT_BITS +: `XCP_SEL_BITS]};
      assign hit = (word_tgt == (`XCP_ADR_OUT_W)'(gi));
      // mode high: only named output; mode low: whole frame
      assign route_d[gi] = !apply ? route_q[gi] :
                           sync_q.mode_sel ?
                             (hit ? word_route : route_q[gi]) :
                             frame_route;
    end
  endgenerate

  // only the configure path writes the active bank
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `XCP_NUM_OUT; i++) begin
        route_q[i] <= '{off: `XCP_RST_OFF, sel: `XCP_RST_SEL};
      end
    end else begin
      route_q <= route_d;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign sdout   = sdout_q;
  assign route   = route_q;
  assign pending = pend_q;
endmodule
`default_nettype wire

/* File: inc/xcp_params.svh */
// constants for the crosspoint serial configuration port
`ifndef XCP_PARAMS_SVH
`define XCP_PARAMS_SVH
`define XCP_NUM_OUT     8
`define XCP_FRAME_BITS  40
`define XCP_WORD_BITS   8
`define XCP_SLOT_BITS   5
`define XCP_SEL_BITS    4
`define XCP_SER_OFF_POS 4
`define XCP_ADR_OUT_LSB 0
`define XCP_ADR_OUT_W   3
`define XCP_ADR_IN_LSB  3
`define XCP_ADR_OFF_POS 7
`define XCP_WORD_LSB    32
`define XCP_RST_SEL     4'h0
`define XCP_RST_OFF     1'b1
`endif

/* File: inc/xcp_pkg.sv */
// types for the crosspoint serial configuration port
package xcp_pkg;
  // one output's active setting
  typedef struct packed {
    logic       off;
    logic [3:0] sel;
  } xcp_route_s;
  // pins sampled from the host side
  typedef struct packed {
    logic sclk;
    logic sdin;
    logic cs_b;
    logic mode_sel;
    logic cfg;
  } xcp_pins_s;
endpackage

/* File: bench/xcp_port_asserts.sv */
// checker for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module xcp_port_asserts (
  input wire logic                 core_clk,
  input wire logic                 rst_b,
  input wire logic                 sclk,
  input wire logic                 sdin,
  input wire logic                 cs_b,
  input wire logic                 mode_sel,
  input wire logic                 cfg,
  input wire logic                 sdout,
  input wire xcp_pkg::xcp_route_s [7:0] route,
  input wire logic                 pending
);
  // ==========
  // properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // number of outputs whose setting differs
  function automatic int nchg(input logic [39:0] a, input logic [39:0] b);
    nchg = 0;
    for (int i = 0; i < 8; i++)
      nchg += int'(a[5*i+:5] != b[5*i+:5]);
  endfunction
  a_route_cause: assert property ($changed(route) |->
    $past(pending) && $past(cfg, 3)) else $error("route moved uncued");
  a_pend_clear: assert property ($fell(pending) |->
    $past(cfg, 3)) else $error("pending cleared uncued");
  a_cfg_apply: assert property ($rose(cfg) && pending |->
    ##[2:6] !pending) else $error("configure not taken");
  a_cfg_quiet: assert property ($rose(cfg) && !pending |=>
    $stable(route) [*6]) else $error("idle configure acted");
  a_cs_gate: assert property ($rose(pending) |->
    $past(cs_b, 4) == 1'b0) else $error("shift with select high");
  a_fall_take: assert property ($rose(pending) |->
    !$past(sclk) && $past(sclk, 6)) else $error("shift off falling edge");
  a_sdout_shift: assert property ($changed(sdout) |->
    pending) else $error("sdout moved without shift");
  a_addr_one: assert property ($changed(route) && mode_sel |->
    nchg(route, $past(route)) == 1) else $error("addressed multi change");
endmodule
bind xcp_port xcp_port_asserts i_xcp_port_asserts (.core_clk(core_clk),
  .rst_b(rst_b), .sclk(sclk), .sdin(sdin), .cs_b(cs_b),
  .mode_sel(mode_sel), .cfg(cfg), .sdout(sdout), .route(route),
  .pending(pending));
`default_nettype wire

/* File: bench/xcp_host.sv */
// host model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module xcp_host (
  input  wire logic core_clk,
  output var logic  sclk,
  output var logic  sdin,
  output var logic  cs_b
);
  // ==========
  // pin sequencing
  initial begin
    sclk = 1'b0;
    sdin = 1'b0;
    cs_b = 1'b1;
  end
  // one half period of the 320 ns link clock
  task automatic half();
    repeat (4) @(posedge core_clk);
  endtask
  // one frame: select low, n bits, select high, one more rise
  task automatic send(input logic [39:0] d, input int n);
    cs_b <= 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      sdin <= d[i];
      half();
      sclk <= 1'b0;
      half();
    end
    cs_b <= 1'b1;
    sdin <= ~sdin;
    half();
    sclk <= 1'b1;
    half();
    sclk <= 1'b0;
    half();
  endtask
  // clock and data noise with select high
  task automatic junk(input int k);
    for (int i = 0; i < k; i++) begin
      sclk <= ~sclk;
      sdin <= 1'($urandom);
      half();
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/xcp_port_test.sv */
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module xcp_port_test;
  import xcp_pkg::*;
  logic             core_clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             mode_sel = 1'b0;
  logic             cfg = 1'b0;
  logic             sclk, sdin, cs_b, sdout, pending;
  xcp_route_s [7:0] route, model;
  logic [39:0]      d;
  logic [7:0]       w;
  int               fails = 0;
  int               check_count = 0;
  // ==========
  // clock, design and host
  always #20 core_clk = ~core_clk;
  xcp_port i_xcp_port (.core_clk(core_clk), .rst_b(rst_b), .sclk(sclk),
    .sdin(sdin), .cs_b(cs_b), .mode_sel(mode_sel), .cfg(cfg),
    .sdout(sdout), .route(route), .pending(pending));
  xcp_host i_xcp_host (.core_clk(core_clk), .sclk(sclk), .sdin(sdin),
    .cs_b(cs_b));
  // compare and count
  task automatic chk(input string s, input logic [39:0] e, g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  // mode first, then a configure pulse
  task automatic pulse(input logic m);
    mode_sel <= m;
    repeat (4) @(posedge core_clk);
    cfg <= 1'b1;
    repeat (8) @(posedge core_clk);
    cfg <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  // serial frame to expected routes
  function automatic logic [39:0] ser_exp(input logic [39:0] f);
    for (int i = 0; i < 8; i++)
      ser_exp[5*i+:5] = {f[5*i+4], f[5*i+:4]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    void'($urandom(32'hf5c8));
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk("reset route", {8{5'h10}}, route);
    d = 40'({$urandom, $urandom});
    d[4] = 1'b0;
    d[39] = 1'b1;
    d[34:32] = 3'h0;
    i_xcp_host.send(d, 40);
    chk("route held", {8{5'h10}}, route);
    chk("pending", 40'h1, 40'(pending));
    pulse(1'b0);
    chk("serial", ser_exp(d), route);
    pulse(1'b1);
    chk("cfg again", ser_exp(d), route);
    i_xcp_host.junk(8);
    repeat (4) @(posedge core_clk);
    chk("select high", 40'h0, 40'(pending));
    $display("test serial done");
    model = ser_exp(d);
    for (int i = 0; i < 8; i++) begin
      w = 8'($urandom);
      w[2:0] = 3'(i);
      i_xcp_host.send(40'(w), 8);
      chk("sdout", 40'(d[7]), 40'(sdout));
      d = {w, d[39:8]};
      pulse(1'b1);
      model[w[2:0]] = {w[7], w[6:3]};
      chk("addressed", model, route);
    end
    $display("test addressed done");
    report_and_stop();
  end
  // watchdog
  initial begin
    #1_000_000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
